// [src/vds_consts.vh]
`ifndef VDS_CONSTS_VH
`define VDS_CONSTS_VH
// register word offsets
`define VDS_OFF_CTRL     4'h0
`define VDS_OFF_MODE     4'h1
`define VDS_OFF_IMAX     4'h2
`define VDS_OFF_DITHER   4'h3
`define VDS_OFF_TEMP     4'h4
`define VDS_OFF_STATUS   4'h5
`define VDS_OFF_IRQSTAT  4'h6
`define VDS_OFF_IRQMASK  4'h7
`define VDS_OFF_CURVE    4'h8
// control fields
`define VDS_CTRL_EN      0
`define VDS_CTRL_ACK     1
`define VDS_CTRL_CURVE   2
`define VDS_CTRL_BUS     3
// status fields
`define VDS_ST_ACTIVE    0
`define VDS_ST_DERATE    1
`define VDS_ST_THERR     2
`define VDS_ST_ERR       3
`define VDS_ST_REMOTE    4
`define VDS_ST_DIRTY     5
// interrupt events
`define VDS_EV_DERATE    0
`define VDS_EV_THERR     1
`define VDS_EV_MODEREJ   2
`define VDS_EV_SAVED     3
// temperatures in degrees C
`define VDS_TEMP_DERATE  8'h50
`define VDS_TEMP_SHUT    8'h5A
// reset values
`define VDS_RST_IMAX     12'hFFF
`define VDS_RST_DITHER   16'h1010
// derating slope: current step per degree, shift count
`define VDS_DERATE_SHIFT 7
// pwm period 1 kHz at 25 MHz
`define VDS_PWM_HZ       1000
`define VDS_CLK_HZ       25000000
`define VDS_PWM_CYC      (`VDS_CLK_HZ / `VDS_PWM_HZ)
`endif

// [src/vds_pwm_channel.v]
`timescale 1ns/10ps
// ----------------------------------------------------------------
// pwm channel with superimposed dither
// ----------------------------------------------------------------
module vds_pwm_channel #(
  parameter PERIOD = 25000,
  parameter W = 15
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // setpoint
  input wire [11:0] level,
  input wire [7:0] ditherDiv,
  input wire [7:0] ditherAmp,
  input wire block,
  // drive
  output reg pwmOut
);
  reg [W-1:0] cnt_ff;
  reg [7:0] dCnt_ff;
  reg dPhase_ff;
  reg [12:0] dutyEff;
  reg [W-1:0] thresh;
  reg [31:0] prod;
  // period counter and dither phase toggling once per ditherDiv+1 periods
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= {W{1'b0}};
      dCnt_ff <= 8'h00;
      dPhase_ff <= 1'b0;
    end else if (cnt_ff == PERIOD - 1) begin
      cnt_ff <= {W{1'b0}};
      if (dCnt_ff >= ditherDiv) begin
        dCnt_ff <= 8'h00;
        dPhase_ff <= ~dPhase_ff;
      end else begin
        dCnt_ff <= dCnt_ff + 8'h01;
      end
    end else begin
      cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end
  // duty with dither offset, clipped
  always @* begin
    if (dPhase_ff)
      dutyEff = ({1'b0, level} > {5'h00, ditherAmp}) ? {1'b0, level} - {5'h00, ditherAmp} : 13'h0000;
    else
      dutyEff = ({1'b0, level} + {5'h00, ditherAmp} > 13'h0FFF) ? 13'h0FFF : {1'b0, level} + {5'h00, ditherAmp};
    // scale 12-bit duty to the period, keep the bits that fit the counter
    prod = dutyEff[11:0] * PERIOD;
    thresh = prod[W+11:12];
  end
  // output register
  always @(posedge clock or posedge rst) begin
    if (rst)
      pwmOut <= 1'b0;
    else
      pwmOut <= ~block && (cnt_ff < thresh);
  end
endmodule

// [src/vds_supervisor.v]
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/10ps
`include "vds_consts.vh"
module vds_supervisor #(
  parameter PERIOD = `VDS_PWM_CYC,
  parameter CURVE_N = 16
) (
  // clock and reset
  input wire clock,
  input wire rst,
  // avalon slave
  input wire [3:0] avsAddress,
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsWritedata,
  input wire [1:0] avsSource,
  output reg [31:0] avsReaddata,
  output reg avsWaitrequest,
  // field pins and sensors
  input wire enablePin,
  input wire [7:0] tempIn,
  input wire [11:0] presetA,
  input wire [11:0] presetB,
  // nonvolatile storage
  input wire nvReady,
  output reg nvWrite_ff,
  output reg [3:0] nvAddr_ff,
  output reg [31:0] nvData_ff,
  // outputs
  output reg errorPin_ff,
  output reg irq_ff,
  output wire solenoidA,
  output wire solenoidB
);
  localparam ST_DISABLED = 1'b0;
  localparam ST_ACTIVE = 1'b1;

  reg state_ff, remote_ff, toolEn_ff, curveOn_ff, ackReq_ff, thErr_ff, errLatch_ff, derate_ff;
  reg [2:0] enSync_ff;
  reg [11:0] imax_ff, limit_ff, outA_ff, outB_ff;
  reg [15:0] dither_ff;
  reg [3:0] irqStat_ff, irqMask_ff;
  reg [7:0] temp_ff;
  reg [11:0] curve_ff [0:CURVE_N-1];
  reg [8:0] dirty_ff;
  reg acked_ff;
  reg enHeld_ff, enSrcPrev_ff;
  wire enLocal;
  reg nxt_state;
  wire enSrc, wrAck, rdAck;
  wire [3:0] events;
  reg modeRej, derateNow, thNow;
  reg [11:0] nxt_limit, mapA, mapB;
  reg [3:0] dIdx;
  integer i, k;

  // ----------------------------------------------------------------
  // bus handshake: one wait cycle, answer on second edge
  // ----------------------------------------------------------------
  assign wrAck = avsWrite && !avsWaitrequest;
  assign rdAck = avsRead && !avsWaitrequest;
  always @(posedge clock or posedge rst) begin
    if (rst)
      avsWaitrequest <= 1'b1;
    else
      avsWaitrequest <= !((avsRead || avsWrite) && avsWaitrequest);
  end

  // ----------------------------------------------------------------
  // pin synchroniser and enable source
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      enSync_ff <= 3'h0;
      enHeld_ff <= 1'b0;
    end else begin
      enSync_ff <= {enSync_ff[1:0], enablePin};
      enHeld_ff <= enLocal;
    end
  end
  // pin level changes only once the last two stages agree
  assign enLocal = (enSync_ff[2] == enSync_ff[1]) ? enSync_ff[1] : enHeld_ff;
  assign enSrc = remote_ff ? toolEn_ff : enLocal;

  // ----------------------------------------------------------------
  // thermal supervision
  // ----------------------------------------------------------------
  always @* begin
    derateNow = (temp_ff >= `VDS_TEMP_DERATE);
    thNow = (temp_ff > `VDS_TEMP_SHUT);
    if (derateNow && ({4'h0, temp_ff - `VDS_TEMP_DERATE} << `VDS_DERATE_SHIFT) < imax_ff)
      nxt_limit = imax_ff - ({4'h0, temp_ff - `VDS_TEMP_DERATE} << `VDS_DERATE_SHIFT);
    else if (derateNow)
      nxt_limit = 12'h000;
    else
      nxt_limit = imax_ff;
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      temp_ff <= 8'h00;
      derate_ff <= 1'b0;
      limit_ff <= 12'h000;
      thErr_ff <= 1'b0;
    end else begin
      temp_ff <= tempIn;
      derate_ff <= derateNow;
      limit_ff <= nxt_limit;
      // thermal error set; clear on cool and ack
      if (thNow)
        thErr_ff <= 1'b1;
      else if (ackReq_ff && !derateNow)
        thErr_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // enable state machine
  // ----------------------------------------------------------------
  always @* begin
    case (state_ff)
      ST_DISABLED: nxt_state = (enSrc && !thErr_ff) ? ST_ACTIVE : ST_DISABLED;
      ST_ACTIVE: nxt_state = (!enSrc || thErr_ff) ? ST_DISABLED : ST_ACTIVE;
      default: nxt_state = ST_DISABLED;
    endcase
  end
  always @(posedge clock or posedge rst) begin
    if (rst)
      state_ff <= ST_DISABLED;
    else
      state_ff <= nxt_state;
  end
  // error held until disable then enable
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      errLatch_ff <= 1'b0;
      errorPin_ff <= 1'b0;
      enSrcPrev_ff <= 1'b0;
    end else begin
      enSrcPrev_ff <= enSrc;
      // only a fresh enable edge from pin or tool releases it, not an automatic resume
      if (thErr_ff)
        errLatch_ff <= 1'b1;
      else if (enSrc && !enSrcPrev_ff)
        errLatch_ff <= 1'b0;
      errorPin_ff <= errLatch_ff | thErr_ff;
    end
  end

  // ----------------------------------------------------------------
  // register writes and nonvolatile mirror
  // ----------------------------------------------------------------
  always @* begin
    modeRej = wrAck && avsAddress == `VDS_OFF_MODE && state_ff == ST_ACTIVE;
  end
  // tool or fieldbus source accepted alike
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      remote_ff <= 1'b0;
      toolEn_ff <= 1'b0;
      curveOn_ff <= 1'b0;
      ackReq_ff <= 1'b0;
      imax_ff <= `VDS_RST_IMAX;
      dither_ff <= `VDS_RST_DITHER;
      irqMask_ff <= 4'h0;
      dirty_ff <= 9'h000;
      for (i = 0; i < CURVE_N; i = i + 1)
        curve_ff[i] <= 12'h000;
    end else begin
      ackReq_ff <= 1'b0;
      // flag cleared when its value enters the storage request; a write in the same cycle sets it again
      if (!nvWrite_ff && dIdx != 4'hF)
        dirty_ff[dIdx] <= 1'b0;
      if (wrAck) begin
        case (avsAddress)
          `VDS_OFF_CTRL: begin
            toolEn_ff <= avsWritedata[`VDS_CTRL_EN];
            ackReq_ff <= avsWritedata[`VDS_CTRL_ACK];
            curveOn_ff <= avsWritedata[`VDS_CTRL_CURVE];
            dirty_ff[0] <= 1'b1;
          end
          // mode taken only when disabled; refused when active
          `VDS_OFF_MODE: if (state_ff == ST_DISABLED) begin
            remote_ff <= avsWritedata[0];
            dirty_ff[1] <= 1'b1;
          end
          `VDS_OFF_IMAX: begin
            imax_ff <= avsWritedata[11:0];
            dirty_ff[2] <= 1'b1;
          end
          `VDS_OFF_DITHER: begin
            dither_ff <= avsWritedata[15:0];
            dirty_ff[3] <= 1'b1;
          end
          `VDS_OFF_IRQMASK: irqMask_ff <= avsWritedata[3:0];
          `VDS_OFF_CURVE: begin
            curve_ff[avsWritedata[19:16]] <= avsWritedata[11:0];
            dirty_ff[4] <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end
  // lowest pending parameter goes to storage
  always @* begin
    dIdx = 4'hF;
    for (k = 4; k >= 0; k = k - 1)
      if (dirty_ff[k])
        dIdx = k[3:0];
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      nvWrite_ff <= 1'b0;
      nvAddr_ff <= 4'h0;
      nvData_ff <= 32'h00000000;
    end else if (nvWrite_ff) begin
      if (nvReady)
        nvWrite_ff <= 1'b0;
    end else if (dIdx != 4'hF) begin
      nvWrite_ff <= 1'b1;
      nvAddr_ff <= dIdx;
      case (dIdx)
        4'h0: nvData_ff <= {29'h0000000, curveOn_ff, 1'b0, toolEn_ff};
        4'h1: nvData_ff <= {31'h0000000, remote_ff};
        4'h2: nvData_ff <= {20'h00000, imax_ff};
        4'h3: nvData_ff <= {16'h0000, dither_ff};
        default: nvData_ff <= {20'h00000, curve_ff[0]};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupts: sticky, write one to clear, set wins
  // ----------------------------------------------------------------
  assign events = {nvWrite_ff & nvReady, modeRej, thNow & !thErr_ff, derateNow & !derate_ff};
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irqStat_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      if (wrAck && avsAddress == `VDS_OFF_IRQSTAT)
        irqStat_ff <= (irqStat_ff & ~avsWritedata[3:0]) | events;
      else
        irqStat_ff <= irqStat_ff | events;
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst)
      avsReaddata <= 32'h00000000;
    else if (avsRead && avsWaitrequest) begin
      case (avsAddress)
        `VDS_OFF_CTRL: avsReaddata <= {29'h0, curveOn_ff, 1'b0, toolEn_ff};
        `VDS_OFF_MODE: avsReaddata <= {31'h0, remote_ff};
        `VDS_OFF_IMAX: avsReaddata <= {20'h0, imax_ff};
        `VDS_OFF_DITHER: avsReaddata <= {16'h0, dither_ff};
        `VDS_OFF_TEMP: avsReaddata <= {24'h0, temp_ff};
        `VDS_OFF_STATUS: avsReaddata <= {26'h0, (|dirty_ff) | nvWrite_ff, remote_ff, errorPin_ff, thErr_ff,
          derate_ff, state_ff};
        `VDS_OFF_IRQSTAT: avsReaddata <= {28'h0, irqStat_ff};
        `VDS_OFF_IRQMASK: avsReaddata <= {28'h0, irqMask_ff};
        default: avsReaddata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // current setpoints
  // ----------------------------------------------------------------
  always @* begin
    mapA = curveOn_ff ? curve_ff[presetA[11:8]] : presetA;
    mapB = curveOn_ff ? curve_ff[presetB[11:8]] : presetB;
  end
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      outA_ff <= 12'h000;
      outB_ff <= 12'h000;
    end else if (state_ff != ST_ACTIVE || thErr_ff) begin
      outA_ff <= 12'h000;
      outB_ff <= 12'h000;
    end else begin
      outA_ff <= (mapA > limit_ff) ? limit_ff : mapA;
      outB_ff <= (mapB > limit_ff) ? limit_ff : mapB;
    end
  end

  // ----------------------------------------------------------------
  // pwm drivers
  // ----------------------------------------------------------------
  // dither rate and depth independent
  vds_pwm_channel #(.PERIOD(PERIOD)) chanA (
    .clock(clock), .rst(rst), .level(outA_ff), .ditherDiv(dither_ff[15:8]),
    .ditherAmp(dither_ff[7:0]), .block(thErr_ff || state_ff != ST_ACTIVE), .pwmOut(solenoidA));
  vds_pwm_channel #(.PERIOD(PERIOD)) chanB (
    .clock(clock), .rst(rst), .level(outB_ff), .ditherDiv(dither_ff[15:8]),
    .ditherAmp(dither_ff[7:0]), .block(thErr_ff || state_ff != ST_ACTIVE), .pwmOut(solenoidB));
endmodule

// [bench/vds_supervisor_asserts.sv]
`timescale 1ns/10ps
// ----
// port checks of the supervisor
// ----
module vds_supervisor_asserts (
  // clock and reset
  input wire clock,
  input wire rst,
  // avalon slave
  input wire avsRead,
  input wire avsWrite,
  input wire [31:0] avsReaddata,
  input wire avsWaitrequest,
  // sensor, storage and drive
  input wire [7:0] tempIn,
  input wire nvReady,
  input wire nvWrite_ff,
  input wire [3:0] nvAddr_ff,
  input wire [31:0] nvData_ff,
  input wire errorPin_ff,
  input wire solenoidA,
  input wire solenoidB
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // bus answers: one wait cycle, one ready cycle, data moves only on a read
  AST_WAIT_ONE: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("request not answered after one wait cycle");
  AST_WAIT_PULSE: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("wait released for more than one cycle");
  AST_WAIT_IDLE: assert property (!avsRead && !avsWrite |=> avsWaitrequest)
    else $error("wait released without a request");
  AST_RD_STAND: assert property ($changed(avsReaddata) |-> avsRead && !avsWaitrequest)
    else $error("read data moved outside a read");
  // outputs quiet right after reset
  AST_RST_QUIET: assert property ($fell(rst) |-> !solenoidA && !solenoidB && !errorPin_ff)
    else $error("output active right after reset");
  // overheating trips the error pin and blocks both drives
  AST_HOT_ERR: assert property ((tempIn > 8'h5A)[*4] |=> errorPin_ff)
    else $error("no error after overheating");
  AST_HOT_BLOCK: assert property ((tempIn > 8'h5A)[*4] |=> !solenoidA && !solenoidB)
    else $error("drive active while overheated");
  // storage request held until taken
  AST_NV_HOLD: assert property (nvWrite_ff && !nvReady |=>
    nvWrite_ff && $stable(nvAddr_ff) && $stable(nvData_ff))
    else $error("storage request changed before taken");
endmodule
bind vds_supervisor vds_supervisor_asserts u_vds_supervisor_asserts (.clock, .rst, .avsRead, .avsWrite,
  .avsReaddata, .avsWaitrequest, .tempIn, .nvReady, .nvWrite_ff, .nvAddr_ff, .nvData_ff, .errorPin_ff,
  .solenoidA, .solenoidB);

// [bench/vds_nv_model.sv]
`timescale 1ns/10ps
// ----
// storage partner
// ----
module vds_nv_model (
  // clock and reset
  input wire clock,
  input wire rst,
  // answer speed
  input wire slow,
  // write request
  input wire nvWrite_ff,
  input wire [3:0] nvAddr_ff,
  input wire [31:0] nvData_ff,
  output reg nvReady,
  // last stored word
  output reg [3:0] lastAddr,
  output reg [31:0] lastData
);
  reg [2:0] waitCnt;
  // word stored when ready meets a request
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      nvReady <= 1'h0;
      waitCnt <= 3'h0;
      lastAddr <= 4'h0;
      lastData <= 32'h0;
    end else if (nvWrite_ff && nvReady) begin
      nvReady <= 1'h0;
      waitCnt <= 3'h0;
      lastAddr <= nvAddr_ff;
      lastData <= nvData_ff;
    end else if (nvWrite_ff) begin
      waitCnt <= waitCnt + 3'h1;
      nvReady <= !slow || waitCnt == 3'h4; // slow partner stalls four cycles
    end
  end
endmodule

// [bench/valve_driver_supervisor_bench.sv]
`timescale 1ns/10ps
module valve_driver_supervisor_bench;
  localparam integer PER = 100;
  // ----
  // signals
  // ----
  reg clock = 1'h0, rst = 1'h1, avsRead = 1'h0, avsWrite = 1'h0, enablePin = 1'h0, slow = 1'h0;
  reg [3:0] avsAddress = 4'h0;
  reg [31:0] avsWritedata = 32'h0, rd;
  reg [1:0] avsSource = 2'h0;
  reg [7:0] tempIn = 8'h19, t;
  reg [11:0] presetA = 12'h0, presetB = 12'h0, v;
  wire [31:0] avsReaddata, nvData_ff, lastData;
  wire [3:0] nvAddr_ff, lastAddr;
  wire avsWaitrequest, nvReady, nvWrite_ff, errorPin_ff, irq_ff, solenoidA, solenoidB;
  integer seed = 97, n_mismatch = 0, total_checks = 0, i, hi;
  // 40 ns clock
  always #20 clock = ~clock;
  // design and storage partner
  vds_supervisor #(.PERIOD(PER)) u_vds_supervisor (.clock, .rst, .avsAddress, .avsRead, .avsWrite,
    .avsWritedata, .avsSource, .avsReaddata, .avsWaitrequest, .enablePin, .tempIn, .presetA, .presetB,
    .nvReady, .nvWrite_ff, .nvAddr_ff, .nvData_ff, .errorPin_ff, .irq_ff, .solenoidA, .solenoidB);
  vds_nv_model u_vds_nv_model (.clock, .rst, .slow, .nvWrite_ff, .nvAddr_ff, .nvData_ff, .nvReady,
    .lastAddr, .lastData);
  // ----
  // tasks
  // ----
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task chk_reg(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pin(input got, input exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until wait drops
  task bus(input wr, input [3:0] a, input [31:0] d);
    integer n;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    n = 0;
    @(posedge clock);
    while (avsWaitrequest !== 1'h0 && n < 20) begin
      n++;
      @(posedge clock);
    end
    rd = avsReaddata;
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
    if (n == 20) begin
      n_mismatch++;
      report_and_stop;
    end
    @(posedge clock);
  endtask
  // drive cycles seen over two pwm periods
  task pwm_count;
    hi = 0;
    repeat (PER * 2) begin
      @(posedge clock);
      if (solenoidA !== 1'h0 || solenoidB !== 1'h0) begin
        hi++;
      end
    end
  endtask
  function [31:0] exp_status(input act, input [7:0] tc, input therr, input errp, input remote);
    exp_status = {27'h0, remote, errp, therr, tc >= 8'h50, act};
  endfunction
  // ----
  // scenarios
  // ----
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    // power-on state, defaults, unmapped place
    bus(1'h0, 4'h5, 32'h0);
    chk_reg(rd, exp_status(1'h0, tempIn, 1'h0, 1'h0, 1'h0));
    bus(1'h0, 4'h2, 32'h0);
    chk_reg(rd, 32'hFFF);
    bus(1'h0, 4'h9, 32'h0);
    chk_reg(rd, 32'h0);
    presetA <= 12'($random(seed)) | 12'h800;
    presetB <= 12'($random(seed)) | 12'h800;
    pwm_count;
    chk_reg(hi, 32'h0);
    // local enable follows the pin, drive then runs
    enablePin <= 1'h1;
    repeat (6) @(posedge clock);
    bus(1'h0, 4'h5, 32'h0);
    chk_reg(rd & 32'h1F, exp_status(1'h1, tempIn, 1'h0, 1'h0, 1'h0));
    pwm_count;
    chk_reg(hi != 0, 32'h1);
    // mode change refused while active, raising the masked interrupt
    bus(1'h1, 4'h1, 32'h1);
    bus(1'h0, 4'h1, 32'h0);
    chk_reg(rd & 32'h1, 32'h0);
    bus(1'h1, 4'h7, 32'h4);
    repeat (2) @(posedge clock);
    chk_pin(irq_ff, 1'h1);
    bus(1'h1, 4'h6, 32'h4);
    repeat (2) @(posedge clock);
    chk_pin(irq_ff, 1'h0);
    // derating flag at the threshold edges and random temperatures
    for (i = 0; i < 10; i++) begin
      t = (i == 0) ? 8'h4F : (i == 1) ? 8'h50 : 8'h3C + 8'({$random(seed)} % 30);
      tempIn <= t;
      repeat (3) @(posedge clock);
      bus(1'h0, 4'h5, 32'h0);
      chk_reg(rd & 32'h3, exp_status(1'h1, t, 1'h0, 1'h0, 1'h0) & 32'h3);
    end
    // thermal trip, acknowledge refused while warm, error kept until re-enable
    tempIn <= 8'h5F;
    repeat (6) @(posedge clock);
    chk_pin(errorPin_ff, 1'h1);
    pwm_count;
    chk_reg(hi, 32'h0);
    tempIn <= 8'h55;
    bus(1'h1, 4'h0, 32'h2);
    bus(1'h0, 4'h5, 32'h0);
    chk_reg(rd & 32'h4, 32'h4);
    tempIn <= 8'h19;
    repeat (2) @(posedge clock);
    bus(1'h1, 4'h0, 32'h2);
    bus(1'h0, 4'h5, 32'h0);
    chk_reg(rd & 32'h4, 32'h0);
    chk_pin(errorPin_ff, 1'h1);
    enablePin <= 1'h0;
    repeat (6) @(posedge clock);
    enablePin <= 1'h1;
    repeat (6) @(posedge clock);
    chk_pin(errorPin_ff, 1'h0);
    // tool mode taken while disabled, then tool enable
    enablePin <= 1'h0;
    repeat (6) @(posedge clock);
    bus(1'h1, 4'h1, 32'h1);
    bus(1'h1, 4'h0, 32'h1);
    repeat (2) @(posedge clock);
    bus(1'h0, 4'h5, 32'h0);
    chk_reg(rd & 32'h1F, exp_status(1'h1, tempIn, 1'h0, 1'h0, 1'h1));
    // user curve on maps both presets through zeroed entries, off bypasses again
    bus(1'h1, 4'h0, 32'h5);
    repeat (2) @(posedge clock);
    pwm_count;
    chk_reg(hi, 32'h0);
    bus(1'h1, 4'h0, 32'h1);
    repeat (2) @(posedge clock);
    pwm_count;
    chk_reg(hi != 0, 32'h1);
    // fieldbus write stored through a slow partner
    slow <= 1'h1;
    avsSource <= 2'h1;
    v = 12'($random(seed));
    bus(1'h1, 4'h2, {20'h0, v});
    for (i = 0; i < 200 && lastAddr !== 4'h2; i++) begin
      @(posedge clock);
    end
    chk_reg(lastAddr, 32'h2);
    chk_reg(lastData & 32'hFFF, {20'h0, v});
    bus(1'h0, 4'h2, 32'h0);
    chk_reg(rd, {20'h0, v});
    report_and_stop;
  end
endmodule
